// File: hdl/estc_bank.sv
// Receive sync, elastic store, error counter, watermark and interleave
// configuration for sixteen framer ports, reached over AXI4-Lite.
// Assumes one clock, synchronous active-low reset, a 16-bit byte address.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "estc_defines.svh"
module estc_bank #(
  parameter logic [23:0] SECOND_CYC = 24'(`ESTC_SECOND_CYC), // One-second count
  parameter logic [23:0] T1_IVL_CYC = 24'(`ESTC_T1_IVL_CYC), // T1 interval count
  parameter logic [23:0] E1_IVL_CYC = 24'(`ESTC_E1_IVL_CYC)  // E1 interval count
) (
  input  wire logic        CLK,             // 10 MHz bank clock
  input  wire logic        RESET_N,         // Synchronous reset, active low
  input  wire logic [15:0] S_AXI_AWADDR,    // Write address
  input  wire logic        S_AXI_AWVALID,   // Write address valid
  output logic             S_AXI_AWREADY,   // Write address ready
  input  wire logic [31:0] S_AXI_WDATA,     // Write data
  input  wire logic [3:0]  S_AXI_WSTRB,     // Write byte strobes
  input  wire logic        S_AXI_WVALID,    // Write data valid
  output logic             S_AXI_WREADY,    // Write data ready
  output logic [1:0]       S_AXI_BRESP,     // Write response
  output logic             S_AXI_BVALID,    // Write response valid
  input  wire logic        S_AXI_BREADY,    // Write response ready
  input  wire logic [15:0] S_AXI_ARADDR,    // Read address
  input  wire logic        S_AXI_ARVALID,   // Read address valid
  output logic             S_AXI_ARREADY,   // Read address ready
  output logic [31:0]      S_AXI_RDATA,     // Read data
  output logic [1:0]       S_AXI_RRESP,     // Read response
  output logic             S_AXI_RVALID,    // Read data valid
  input  wire logic        S_AXI_RREADY,    // Read data ready
  input  wire logic [15:0] E1_MODE,         // Per-port E1 framing, same clock
  input  wire logic [15:0] CONVERT_MODE,    // Per-port T1/E1 rate conversion
  input  wire logic [15:0] ES_CLOSE,        // Store pointers under half frame
  input  wire logic        COUNT_LATCH_PIN, // External counter latch, async
  output logic [15:0]      SYNC_OE,         // Sync pin driven as output
  output logic [15:0]      SYNC_MULTIFRAME, // Sync output gives multiframes
  output logic [15:0]      SYNC_DOUBLE,     // Double-wide signaling frame pulse
  output logic [15:0]      SYNC_CRC4,       // Sync pin marks CRC-4 boundaries
  output logic [15:0]      MFSYNC_CRC4,     // Multiframe pin marks CRC-4
  output logic [15:0]      DATA_56K,        // Seven of eight bits carry data
  output logic [15:0]      GAPPED_CLK,      // Gapped channel clock enable
  output logic [63:0]      SLIP_BYTES,      // Slip threshold, 4 bits per port
  output logic [15:0]      ES_MIN_DELAY,    // Store at 32-bit depth
  output logic [15:0]      ES_ENABLE,       // Store in the data path
  output logic [15:0]      ES_ALIGN,        // Align pulse
  output logic [15:0]      ES_RESET,        // Store reset pulse
  output logic [15:0]      COUNT_LATCH,     // Error counter latch pulse
  output logic [15:0]      FS_REPORT,       // Path counter includes Fs bits
  output logic [15:0]      OOS_MULTIFRAME,  // Count multiframes out of sync
  output logic [15:0]      LCV_EXCESS_ZERO, // Line counter includes zeros
  output logic [95:0]      FIFO_MARK,       // Watermark bytes, 6 bits per port
  output logic [15:0]      IBO_FRAME,       // Frame interleave selected
  output logic [15:0]      IBO_ENABLE       // Interleave bus on
);
  localparam int NP = `ESTC_NUM_PORTS;

  // Map a byte address to port and register
  function automatic estc_pkg::estc_dec_t decode(input logic [15:0] addr);
    logic [13:0]         idx;
    estc_pkg::estc_dec_t d;
    idx    = addr[15:2];
    d.port = {idx[13], idx[11:9]};
    unique case (idx[8:0])
      `ESTC_IDX_SYNC_CFG: d.sel = estc_pkg::REG_SYNC;
      `ESTC_IDX_ESTORE:   d.sel = estc_pkg::REG_ESTORE;
      `ESTC_IDX_ERRCNT:   d.sel = estc_pkg::REG_ERRCNT;
      `ESTC_IDX_WMARK:    d.sel = estc_pkg::REG_WMARK;
      `ESTC_IDX_IBO:      d.sel = estc_pkg::REG_IBO;
      `ESTC_IDX_STATUS:   d.sel = estc_pkg::REG_STATUS;
      default:            d.sel = estc_pkg::REG_NONE;
    endcase
    // Second bank sits 2000h above the first: the two upper bits agree
    if (idx[12] != idx[13] || addr[1:0] != 2'h0) begin
      d.sel = estc_pkg::REG_NONE;
    end
    return d;
  endfunction : decode

  // Watermark field to byte level
  function automatic logic [5:0] mark_level(input logic [1:0] f);
    unique case (f)
      2'h0: mark_level = `ESTC_WM_LVL0;
      2'h1: mark_level = `ESTC_WM_LVL1;
      2'h2: mark_level = `ESTC_WM_LVL2;
      2'h3: mark_level = `ESTC_WM_LVL3;
    endcase
  endfunction : mark_level

  logic [7:0] sync_q [NP];
  logic [7:0] sync_d [NP];
  logic [7:0] es_q   [NP];
  logic [7:0] es_d   [NP];
  logic [7:0] ec_q   [NP];
  logic [7:0] ec_d   [NP];
  logic [7:0] wm_q   [NP];
  logic [7:0] wm_d   [NP];
  logic [7:0] ibo_q  [NP];
  logic [7:0] ibo_d  [NP];
  logic [7:0] lcnt   [NP];
  logic [NP-1:0] sec_tick;

  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [15:0] awaddr_q, awaddr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0]  pin_q, pin_d;
  estc_pkg::estc_dec_t wdec, rdec;
  logic        wr_go;

  // Bus handshakes: one write and one read in flight at a time
  assign S_AXI_AWREADY = ~aw_q & ~b_q;
  assign S_AXI_WREADY  = ~w_q & ~b_q;
  assign S_AXI_ARREADY = ~r_q;
  assign S_AXI_BVALID  = b_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = r_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;

  // Bus channel and pin synchroniser next state
  always_comb begin
    aw_d     = aw_q;
    w_d      = w_q;
    b_d      = b_q;
    r_d      = r_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bresp_d  = bresp_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    // Latch pin through two stages before the edge stage reads it
    pin_d    = {pin_q[1:0], COUNT_LATCH_PIN};
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_d     = 1'b1;
      awaddr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_d     = 1'b1;
      wdata_d = S_AXI_WDATA[7:0];
      wstrb_d = S_AXI_WSTRB[0];
    end
    wdec  = decode(awaddr_q);
    wr_go = aw_q & w_q & ~b_q;
    if (wr_go) begin
      aw_d    = 1'b0;
      w_d     = 1'b0;
      b_d     = 1'b1;
      bresp_d = (wdec.sel == estc_pkg::REG_NONE) ? 2'h2 : 2'h0;
    end else if (b_q && S_AXI_BREADY) begin
      b_d = 1'b0;
    end
    rdec = decode(S_AXI_ARADDR);
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      r_d     = 1'b1;
      rresp_d = 2'h0;
      unique case (rdec.sel)
        estc_pkg::REG_SYNC:   rdata_d = {24'h000000, sync_q[rdec.port]};
        estc_pkg::REG_ESTORE: rdata_d = {24'h000000, es_q[rdec.port]};
        estc_pkg::REG_ERRCNT: rdata_d = {24'h000000, ec_q[rdec.port]};
        estc_pkg::REG_WMARK:  rdata_d = {24'h000000, wm_q[rdec.port]};
        estc_pkg::REG_IBO:    rdata_d = {24'h000000, ibo_q[rdec.port]};
        estc_pkg::REG_STATUS: rdata_d = {24'h000000, lcnt[rdec.port]};
        estc_pkg::REG_NONE: begin
          rdata_d = 32'h00000000;
          rresp_d = 2'h2;
        end
      endcase
    end else if (r_q && S_AXI_RREADY) begin
      r_d = 1'b0;
    end
  end

  // Bus channel and synchroniser registers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      b_q      <= 1'b0;
      r_q      <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q  <= 8'h00;
      wstrb_q  <= 1'b0;
      bresp_q  <= 2'h0;
      rresp_q  <= 2'h0;
      rdata_q  <= 32'h00000000;
      pin_q    <= 3'h0;
    end else begin
      aw_q     <= aw_d;
      w_q      <= w_d;
      b_q      <= b_d;
      r_q      <= r_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bresp_q  <= bresp_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
      pin_q    <= pin_d;
    end
  end

  // Register file next state; only byte lane 0 carries a register
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      sync_d[i] = sync_q[i];
      es_d[i]   = es_q[i];
      ec_d[i]   = ec_q[i];
      wm_d[i]   = wm_q[i];
      ibo_d[i]  = ibo_q[i];
      if (wr_go && wstrb_q && wdec.port == 4'(i)) begin
        unique case (wdec.sel)
          estc_pkg::REG_SYNC:   sync_d[i] = {5'h00, wdata_q[2:0]};
          estc_pkg::REG_ESTORE: es_d[i]   = {wdata_q[7:6], 1'b0, wdata_q[4:0]};
          estc_pkg::REG_ERRCNT: ec_d[i]   = wdata_q;
          estc_pkg::REG_WMARK:  wm_d[i]   = {6'h00, wdata_q[1:0]};
          estc_pkg::REG_IBO:    ibo_d[i]  = {3'h0, wdata_q[4:3], 3'h0};
          estc_pkg::REG_STATUS, estc_pkg::REG_NONE: ;
        endcase
      end
    end
  end

  // Register file flops; sync pin starts as an output, as the store starts bypassed
  always_ff @(posedge CLK) begin
    for (int i = 0; i < NP; i++) begin
      if (!RESET_N) begin
        sync_q[i] <= `ESTC_RST_SYNC_CFG;
        es_q[i]   <= `ESTC_RST_ZERO;
        ec_q[i]   <= `ESTC_RST_ZERO;
        wm_q[i]   <= `ESTC_RST_ZERO;
        ibo_q[i]  <= `ESTC_RST_ZERO;
      end else begin
        sync_q[i] <= sync_d[i];
        es_q[i]   <= es_d[i];
        ec_q[i]   <= ec_d[i];
        wm_q[i]   <= wm_d[i];
        ibo_q[i]  <= ibo_d[i];
      end
    end
  end

  // Per-port decode and control slices
  for (genvar p = 0; p < NP; p++) begin : g_port
    estc_cfg_if cfg ();
    logic es_en, sdir_out, e1;

    assign cfg.estore     = es_q[p];
    assign cfg.errcnt     = ec_q[p];
    assign cfg.e1         = E1_MODE[p];
    assign cfg.es_close   = ES_CLOSE[p];
    assign cfg.ext_rise   = pin_q[1] & ~pin_q[2];
    // The first port gets its own tick as the shared second, so setting the bit changes nothing there
    assign cfg.shared_sec = (p == 0) ? sec_tick[0] : sec_tick[0];
    assign sec_tick[p]    = cfg.sec_tick;
    assign lcnt[p]        = cfg.counter_latch_input;

    estc_port_ctl #(
      .SECOND_CYC (SECOND_CYC),
      .T1_IVL_CYC (T1_IVL_CYC),
      .E1_IVL_CYC (E1_IVL_CYC)
    ) u_ctl (
      .CLK     (CLK),
      .RESET_N (RESET_N),
      .cfg     (cfg)
    );

    assign e1       = E1_MODE[p];
    assign es_en    = es_q[p][`ESTC_B_ES_EN];
    // Input direction is only honoured with the store in the path
    assign sdir_out = ~sync_q[p][`ESTC_B_SDIR] | ~es_en;

    // Sync pin and multiframe pin selection
    assign SYNC_OE[p]         = sdir_out;
    assign SYNC_MULTIFRAME[p] = sync_q[p][`ESTC_B_SMS1];
    assign SYNC_DOUBLE[p]     = ~e1 & sdir_out & ~sync_q[p][`ESTC_B_SMS1]
                                & sync_q[p][`ESTC_B_SMS2];
    assign SYNC_CRC4[p]       = e1 & sdir_out & sync_q[p][`ESTC_B_SMS1]
                                & sync_q[p][`ESTC_B_SMS2];
    assign MFSYNC_CRC4[p]     = e1 & sync_q[p][`ESTC_B_SMS2];

    // Elastic store and channel format controls
    assign DATA_56K[p]        = es_q[p][`ESTC_B_DATFMT];
    assign GAPPED_CLK[p]      = es_q[p][`ESTC_B_GAPCLK];
    // Slip zone only matters while converting between line rates
    assign SLIP_BYTES[4*p +: 4] = ~CONVERT_MODE[p] ? 4'h0 :
                                  es_q[p][`ESTC_B_SLIPZONE] ? `ESTC_SLIP_NARROW : `ESTC_SLIP_WIDE;
    assign ES_MIN_DELAY[p]    = es_q[p][`ESTC_B_ES_MINDLY];
    assign ES_ENABLE[p]       = es_en;
    assign ES_ALIGN[p]        = cfg.align_p;
    assign ES_RESET[p]        = cfg.reset_p;

    // Error counter behaviour selects
    assign COUNT_LATCH[p]     = cfg.latch_p;
    assign FS_REPORT[p]       = ~e1 & ec_q[p][`ESTC_B_FS_RPT];
    assign OOS_MULTIFRAME[p]  = ~e1 & ec_q[p][`ESTC_B_OOS_FN];
    assign LCV_EXCESS_ZERO[p] = ec_q[p][`ESTC_B_LCV_FN];

    // Receive FIFO and interleave bus
    assign FIFO_MARK[6*p +: 6] = mark_level(wm_q[p][`ESTC_W_WMARK_LSB +: 2]);
    assign IBO_FRAME[p]        = ibo_q[p][`ESTC_B_IBO_SEL];
    assign IBO_ENABLE[p]       = ibo_q[p][`ESTC_B_IBO_EN];
  end
endmodule : estc_bank
`default_nettype wire

// File: hdl/estc_cfg_if.sv
// Bundle between the register bank and one per-port control slice.
// Assumes both ends run on the bank clock.
`timescale 1ns/1ps
`default_nettype none
interface estc_cfg_if;
  logic [7:0] estore;     // Elastic store control byte
  logic [7:0] errcnt;     // Error counter configuration byte
  logic       e1;         // Port runs E1 framing
  logic       es_close;   // Store pointers closer than half a frame
  logic       ext_rise;   // Rising edge of counter latch pin
  logic       shared_sec; // One-second tick of the first port
  logic       sec_tick;   // This port's one-second tick
  logic       align_p;    // Align command pulse
  logic       reset_p;    // Store reset command pulse
  logic       latch_p;    // Counter latch pulse
  logic [7:0] counter_latch_input;  // Number of latches taken
  modport bank (output estore, errcnt, e1, es_close, ext_rise, shared_sec,
                input  sec_tick, align_p, reset_p, latch_p, counter_latch_input);
  modport ctl  (input  estore, errcnt, e1, es_close, ext_rise, shared_sec,
                output sec_tick, align_p, reset_p, latch_p, counter_latch_input);
endinterface : estc_cfg_if
`default_nettype wire

// File: hdl/estc_defines.svh
// Offsets, field positions, reset values and timing counts for the receive
// configuration bank. Assumes register indices are scaled by four on the bus.
`ifndef ESTC_DEFINES_SVH
`define ESTC_DEFINES_SVH

// Register indices within one port window
`define ESTC_IDX_SYNC_CFG     9'h084
`define ESTC_IDX_ESTORE       9'h085
`define ESTC_IDX_ERRCNT       9'h086
`define ESTC_IDX_WMARK        9'h087
`define ESTC_IDX_IBO          9'h088
`define ESTC_IDX_STATUS       9'h08F
// Port window strides, in register indices
`define ESTC_PORT_STRIDE      14'h0200
`define ESTC_BANK_STRIDE      14'h2000
`define ESTC_NUM_PORTS        16

// Reset values
`define ESTC_RST_SYNC_CFG     8'h04
`define ESTC_RST_ZERO         8'h00

// Sync configuration fields
`define ESTC_B_SMS1           0
`define ESTC_B_SMS2           1
`define ESTC_B_SDIR           2
// Elastic store control fields
`define ESTC_B_ES_EN          0
`define ESTC_B_ES_MINDLY      1
`define ESTC_B_ES_RESET       2
`define ESTC_B_ES_ALIGN       3
`define ESTC_B_SLIPZONE       4
`define ESTC_B_GAPCLK         6
`define ESTC_B_DATFMT         7
// Error counter configuration fields
`define ESTC_B_LCV_FN         0
`define ESTC_B_OOS_FN         1
`define ESTC_B_FS_RPT         2
`define ESTC_B_ACC_MODE       3
`define ESTC_B_IVL_SEL        4
`define ESTC_B_MAN_UPD        5
`define ESTC_B_MAN_SRC        6
`define ESTC_B_SHARED_SEC     7
// Interleave and watermark fields
`define ESTC_B_IBO_EN         3
`define ESTC_B_IBO_SEL        4
`define ESTC_W_WMARK_LSB      0

// Watermark levels in bytes
`define ESTC_WM_LVL0          6'h04
`define ESTC_WM_LVL1          6'h10
`define ESTC_WM_LVL2          6'h20
`define ESTC_WM_LVL3          6'h30
// Slip zone thresholds in bytes
`define ESTC_SLIP_WIDE        4'h9
`define ESTC_SLIP_NARROW      4'h2

// Timing, in nanoseconds and frames
`define ESTC_CLK_NS           100
`define ESTC_SECOND_NS        1000000000
`define ESTC_FRAME_NS         125000
`define ESTC_T1_IVL_FRAMES    333
`define ESTC_E1_IVL_FRAMES    500
`define ESTC_SECOND_CYC       (`ESTC_SECOND_NS / `ESTC_CLK_NS)
`define ESTC_T1_IVL_CYC       ((`ESTC_T1_IVL_FRAMES * `ESTC_FRAME_NS) / `ESTC_CLK_NS)
`define ESTC_E1_IVL_CYC       ((`ESTC_E1_IVL_FRAMES * `ESTC_FRAME_NS) / `ESTC_CLK_NS)

`endif

// File: hdl/estc_pkg.sv
// Types used by the receive configuration bank to decode bus addresses.
// Assumes constants come from estc_defines.svh.
package estc_pkg;
  // Register selected by a bus address
  typedef enum logic [2:0] {REG_NONE, REG_SYNC, REG_ESTORE, REG_ERRCNT, REG_WMARK, REG_IBO, REG_STATUS} estc_reg_t;
  // Decoded bus address
  typedef struct packed {
    logic      [3:0] port;
    estc_reg_t       sel;
  } estc_dec_t;
endpackage : estc_pkg

// File: hdl/estc_port_ctl.sv
// Per-port command edges and error counter update timing.
// Assumes one clock, synchronous active-low reset, inputs already synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "estc_defines.svh"
module estc_port_ctl #(
  parameter logic [23:0] SECOND_CYC = 24'd10000000, // One second
  parameter logic [23:0] T1_IVL_CYC = 24'd416250,   // 333 T1 frames
  parameter logic [23:0] E1_IVL_CYC = 24'd625000    // 500 E1 frames
) (
  input wire logic  CLK,     // Bank clock
  input wire logic  RESET_N, // Synchronous reset, active low
  estc_cfg_if.ctl   cfg      // Configuration and pulses
);
  logic [1:0]  cmd_q, cmd_d;
  logic        man_q, man_d;
  logic [23:0] sec_q, sec_d;
  logic [23:0] ivl_q, ivl_d;
  logic        align_q, align_d, reset_q, reset_d, latch_q, latch_d;
  logic [7:0]  lcnt_q, lcnt_d;
  logic [23:0] ivl_lim;
  logic        sec_hit, ivl_hit, manual_count_update_rise, auto_tick;

  // Next state: edges act once per transition, not while held
  always_comb begin
    cmd_d     = {cfg.estore[`ESTC_B_ES_ALIGN], cfg.estore[`ESTC_B_ES_RESET]};
    man_d     = cfg.errcnt[`ESTC_B_MAN_UPD];
    manual_count_update_rise = man_d & ~man_q;
    align_d   = cmd_d[1] & ~cmd_q[1] & cfg.es_close;
    reset_d   = cmd_d[0] & ~cmd_q[0];
    ivl_lim   = cfg.e1 ? E1_IVL_CYC : T1_IVL_CYC;
    sec_hit   = (sec_q >= SECOND_CYC - 24'h000001);
    ivl_hit   = (ivl_q >= ivl_lim - 24'h000001);
    sec_d     = sec_hit ? 24'h000000 : sec_q + 24'h000001;
    ivl_d     = ivl_hit ? 24'h000000 : ivl_q + 24'h000001;
    // Timed source: frame interval, own second or the shared second
    if (cfg.errcnt[`ESTC_B_IVL_SEL]) begin
      auto_tick = ivl_hit;
    end else if (cfg.errcnt[`ESTC_B_SHARED_SEC]) begin
      auto_tick = cfg.shared_sec;
    end else begin
      auto_tick = sec_hit;
    end
    // Manual mode latches on the pin or on the software bit
    if (cfg.errcnt[`ESTC_B_ACC_MODE]) begin
      latch_d = cfg.errcnt[`ESTC_B_MAN_SRC] ? cfg.ext_rise : manual_count_update_rise;
    end else begin
      latch_d = auto_tick;
    end
    lcnt_d = latch_q ? lcnt_q + 8'h01 : lcnt_q;
  end

  // Registers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cmd_q   <= 2'h0;
      man_q   <= 1'b0;
      sec_q   <= 24'h000000;
      ivl_q   <= 24'h000000;
      align_q <= 1'b0;
      reset_q <= 1'b0;
      latch_q <= 1'b0;
      lcnt_q  <= 8'h00;
    end else begin
      cmd_q   <= cmd_d;
      man_q   <= man_d;
      sec_q   <= sec_d;
      ivl_q   <= ivl_d;
      align_q <= align_d;
      reset_q <= reset_d;
      latch_q <= latch_d;
      lcnt_q  <= lcnt_d;
    end
  end

  assign cfg.sec_tick  = sec_hit;
  assign cfg.align_p   = align_q;
  assign cfg.reset_p   = reset_q;
  assign cfg.latch_p   = latch_q;
  assign cfg.counter_latch_input = lcnt_q;
endmodule : estc_port_ctl
`default_nettype wire

// File: sim/estc_bank_sva.sv
// Checks on the port 1 outputs of the configuration bank.
// Assumes binding into estc_bank by port names.
`timescale 1ns/1ps
`default_nettype none
module estc_bank_sva (
  input wire logic        CLK,      // Bank clock
  input wire logic        RESET_N,  // Sync reset, active low
  input wire logic [15:0] E1_MODE, ES_CLOSE, SYNC_OE, SYNC_MULTIFRAME, SYNC_DOUBLE, // Levels
  input wire logic [15:0] SYNC_CRC4, ES_ENABLE, ES_ALIGN, ES_RESET, COUNT_LATCH,   // Levels, pulses
  input wire logic [15:0] FS_REPORT, OOS_MULTIFRAME, // Counter functions
  input wire logic [95:0] FIFO_MARK  // Watermarks
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // One-cycle pulse; a held command bit must not repeat it
  sequence s_pulse(x);
    x ##1 !x;
  endsequence
  property p_dbl; SYNC_DOUBLE[0] |-> !E1_MODE[0] && SYNC_OE[0] && !SYNC_MULTIFRAME[0]; endproperty
  a_dbl: assert property (p_dbl) else $error("double pulse outside T1 frame output");
  property p_crc; SYNC_CRC4[0] |-> E1_MODE[0] && SYNC_MULTIFRAME[0] && SYNC_OE[0]; endproperty
  a_crc: assert property (p_crc) else $error("CRC-4 marks outside E1 multiframe output");
  property p_oe; !ES_ENABLE[0] |-> SYNC_OE[0]; endproperty
  a_oe: assert property (p_oe) else $error("sync pin input with store bypassed");
  property p_mark; FIFO_MARK[5:0] inside {6'h04, 6'h10, 6'h20, 6'h30}; endproperty
  a_mark: assert property (p_mark) else $error("watermark level off the list");
  // The pulse is registered, so the gate is the distance one cycle earlier
  property p_gate; ES_ALIGN[0] |-> $past(ES_CLOSE[0]); endproperty
  a_gate: assert property (p_gate) else $error("align with pointers already apart");
  property p_aln; $rose(ES_ALIGN[0]) |-> s_pulse(ES_ALIGN[0]); endproperty
  a_aln: assert property (p_aln) else $error("align pulse too long");
  property p_rst; ES_RESET[0] |-> s_pulse(ES_RESET[0]); endproperty
  a_rst: assert property (p_rst) else $error("store reset pulse too long");
  property p_lat; COUNT_LATCH[0] |=> !COUNT_LATCH[0]; endproperty
  a_lat: assert property (p_lat) else $error("counter latch pulse too long");
  property p_e1; E1_MODE[0] |-> !FS_REPORT[0] && !OOS_MULTIFRAME[0]; endproperty
  a_e1: assert property (p_e1) else $error("T1 counter function in E1");
endmodule : estc_bank_sva
bind estc_bank estc_bank_sva i_estc_bank_sva (.*);
`default_nettype wire

// File: sim/estc_bank_tb.sv
// Bench for the configuration bank over AXI4-Lite.
// Assumes shortened timers and the backplane model on port 1.
`timescale 1ns/1ps
`default_nettype none
`include "estc_defines.svh"
module estc_bank_tb;
  localparam int SEC = 20;
  localparam int E1I = 10;
  localparam int T1I = 8;
  localparam logic [8:0] SC = `ESTC_IDX_SYNC_CFG, ES = `ESTC_IDX_ESTORE, EC = `ESTC_IDX_ERRCNT;
  localparam logic [8:0] WM = `ESTC_IDX_WMARK, IB = `ESTC_IDX_IBO, ST = `ESTC_IDX_STATUS;
  logic CLK = 1'b0, RESET_N = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
  logic S_AXI_BREADY = 1'b1, S_AXI_RREADY = 1'b1, COUNT_LATCH_PIN = 1'b0, close;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [7:0] n_align, v, s0;
  logic [31:0] S_AXI_WDATA = 32'h00000000, S_AXI_RDATA;
  logic [15:0] S_AXI_AWADDR = 16'h0000, S_AXI_ARADDR = 16'h0000, E1_MODE = 16'h0000, CONVERT_MODE = 16'h0000;
  logic [15:0] ES_CLOSE, SYNC_OE, SYNC_MULTIFRAME, SYNC_DOUBLE, SYNC_CRC4, MFSYNC_CRC4, DATA_56K, GAPPED_CLK;
  logic [15:0] ES_MIN_DELAY, ES_ENABLE, ES_ALIGN, ES_RESET, COUNT_LATCH, FS_REPORT, OOS_MULTIFRAME;
  logic [15:0] LCV_EXCESS_ZERO, IBO_FRAME, IBO_ENABLE;
  logic [63:0] SLIP_BYTES;
  logic [95:0] FIFO_MARK;
  int error_cnt = 0, n_compared = 0, per;
  assign ES_CLOSE = {15'h0000, close};
  estc_bank #(.SECOND_CYC(24'(SEC)), .T1_IVL_CYC(24'(T1I)), .E1_IVL_CYC(24'(E1I))) i_estc_bank (.*);
  estc_tdm_model i_estc_tdm_model (.clk(CLK), .align(ES_ALIGN[0]), .reset(ES_RESET[0]),
                                   .close(close), .n_align(n_align));
  // 10 MHz bank clock
  always #50 CLK = ~CLK;
  function automatic logic [15:0] ad(input int n, input logic [8:0] idx);
    return 16'((32'(idx) + 32'h00000200 * (n - 1) + 32'h00002000 * ((n - 1) / 8)) * 4);
  endfunction : ad
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // A lost answer ends the run as a failure
  task automatic tmo(input logic ok);
    if (!ok) begin
      error_cnt++;
      end_sim();
    end
  endtask : tmo
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    i = 0;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      i++;
    end while (!S_AXI_BVALID && i < 40);
    tmo(S_AXI_BVALID);
    chk(S_AXI_BRESP, er);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [1:0] er, output logic [7:0] d);
    int i;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    i = 0;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      i++;
    end while (!S_AXI_RVALID && i < 40);
    tmo(S_AXI_RVALID);
    d = S_AXI_RDATA[7:0];
    chk(S_AXI_RRESP, er);
  endtask : rd
  task automatic w1(input logic [8:0] idx, input logic [7:0] d);
    wr(ad(1, idx), d, 2'b00);
  endtask : w1
  initial begin
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    // Reset values, far port windows, unmapped place
    rd(ad(1, SC), 2'b00, v);
    chk({v, SYNC_OE[0], FIFO_MARK[5:0]}, 15'h0244);
    wr(ad(16, IB), 8'h18, 2'b00);
    wr(ad(9, IB), 8'h10, 2'b00);
    rd(ad(16, IB), 2'b00, v);
    chk({v, IBO_ENABLE[15], IBO_FRAME[15], IBO_ENABLE[8], IBO_FRAME[8], IBO_ENABLE[0]}, 13'h031A);
    wr(16'h0010, 8'hFF, 2'b10);
    rd(16'h0010, 2'b10, v);
    // Sync modes in both framings, pin as output
    for (int e = 0; e < 2; e++) begin
      E1_MODE <= 16'(e);
      for (int m = 0; m < 4; m++) begin
        w1(SC, 8'(m));
        chk({SYNC_OE[0], SYNC_MULTIFRAME[0], SYNC_DOUBLE[0], SYNC_CRC4[0], MFSYNC_CRC4[0] | !e[0]},
            {1'b1, m[0], e == 0 && m == 2, e == 1 && m == 3, m[1] | !e[0]});
      end
    end
    // Store on with pin as input, then bypassed forcing output
    w1(ES, 8'hC3);
    w1(SC, 8'h04);
    chk({SYNC_OE[0], ES_ENABLE[0], ES_MIN_DELAY[0], GAPPED_CLK[0], DATA_56K[0]}, 5'h0F);
    w1(ES, 8'h30);
    rd(ad(1, ES), 2'b00, v);
    chk({v, SYNC_OE[0], ES_ENABLE[0], SLIP_BYTES[3:0]}, 14'h0420);
    CONVERT_MODE <= 16'h0001;
    w1(ES, 8'h10);
    chk(SLIP_BYTES[3:0], 4'h2);
    w1(ES, 8'h00);
    chk({SLIP_BYTES[3:0], GAPPED_CLK[0], DATA_56K[0], ES_MIN_DELAY[0], ES_ENABLE[0]}, 8'h90);
    for (int w = 0; w < 4; w++) begin
      w1(WM, 8'(w));
      chk(FIFO_MARK[5:0], w == 0 ? 6'h04 : 6'(w * 16));
    end
    // Align gated by pointer distance; held bit acts once; reset re-arms
    w1(ES, 8'h08);
    w1(ES, 8'h08);
    w1(ES, 8'h00);
    w1(ES, 8'h08);
    repeat (3) @(posedge CLK);
    chk({close, n_align}, 9'h001);
    w1(ES, 8'h04);
    w1(ES, 8'h00);
    w1(ES, 8'h08);
    repeat (3) @(posedge CLK);
    chk({close, n_align}, 9'h002);
    // Manual latch from the software bit, then from the pin
    w1(EC, 8'h08);
    rd(ad(1, ST), 2'b00, s0);
    w1(EC, 8'h28);
    w1(EC, 8'h28);
    w1(EC, 8'h48);
    COUNT_LATCH_PIN <= 1'b1;
    repeat (8) @(posedge CLK);
    COUNT_LATCH_PIN <= 1'b0;
    rd(ad(1, ST), 2'b00, v);
    chk(v, s0 + 8'h02);
    // Timed updates over 202 cycles: shortened second, E1 interval, T1 interval
    for (int k = 0; k < 3; k++) begin
      E1_MODE <= 16'(k < 2);
      w1(EC, k == 0 ? 8'h07 : 8'h17);
      rd(ad(1, ST), 2'b00, s0);
      repeat (200) @(posedge CLK);
      rd(ad(1, ST), 2'b00, v);
      per = k == 0 ? SEC : (k == 1 ? E1I : T1I);
      chk(8'(v - s0) inside {8'(202 / per), 8'(202 / per + 1)}, 1'b1);
    end
    @(posedge CLK);
    chk({FS_REPORT[0], OOS_MULTIFRAME[0], LCV_EXCESS_ZERO[0]}, 3'h7);
    w1(EC, 8'h00);
    chk({FS_REPORT[0], OOS_MULTIFRAME[0], LCV_EXCESS_ZERO[0]}, 3'h0);
    end_sim();
  end
endmodule : estc_bank_tb
`default_nettype wire

// File: sim/estc_tdm_model.sv
// Backplane-side model of the port 1 elastic store pointers.
// Assumes store pulses arrive on the bank clock.
`timescale 1ns/1ps
`default_nettype none
module estc_tdm_model (
  input wire logic   clk,             // Bank clock
  input wire logic   align,           // Align pulse
  input wire logic   reset,           // Store reset pulse
  output logic       close = 1'b1,    // Pointers under half frame
  output logic [7:0] n_align = 8'h00  // Aligns seen
);
  // Reset pulls pointers close again, so a later align is not gated off
  // An unknown pulse before the bank leaves reset is not counted
  always @(posedge clk) begin
    if (align) begin
      n_align <= n_align + 8'h01;
      close   <= 1'b0;
    end
    if (reset) close <= 1'b1;
  end
endmodule : estc_tdm_model
`default_nettype wire
